// ### hw/ssm_display.sv
// Status display and monitor mode logic of the servo drive operator panel
//
// Overview of operation
// - Power-up and stepping with the mode key land in status display mode.
// - Control-supply and main-supply indicators follow their supply levels.
// - Base-block indicator full while unpowered, dimmed while servo is on.
// - Positioning-done lights when residual count is below positioning range.
// - Speed-match lights when speed lies within command plus or minus band.
// - Rotating lights when speed is at or above detection threshold.
// - Pulse-input indicator lit while command pulses are arriving.
// - Speed-input lights when speed command reaches the detection threshold.
// - Torque-input lights when torque command is at least ten percent.
// - Counter-reset indicator lit while the reset input is asserted.
// - Symbol shows unpowered, running, forward or reverse inhibit, or alarm.
// - Monitor mode offers ten indices, zero through nine.
// - Index zero shows measured motor speed.
// - Index one shows speed command, zero in pulse-train position control.
// - Index two shows torque command in percent of rated.
// - Index three shows pulses from U edge, scaled per encoder type.
// - Index four shows electrical angle in degrees.
// - Indices five and six show internal status flags as segment bits.
// - Index seven shows command pulse frequency converted to speed.
// - Index eight shows residual deviation count in command units.
// - Index nine accumulates received input pulses.
// - Up and down pick index, data toggles value view, mode moves on.
//
// Local design decisions: the plain strobed port and the placing of the registers.
`timescale 1ns/1ns
`include "ssm_regs.svh"

module ssm_display (
  input  wire logic                    core_clk_i,
  input  wire logic                    rst_i,
  // Register port
  input  wire logic [`SSM_ADDR_W-1:0]  addr_i,
  input  wire logic [31:0]             wdata_i,
  input  wire logic                    wr_i,
  input  wire logic                    rd_i,
  output logic      [31:0]             rdata_o,
  // Control core
  input  wire ssm_pkg::ssm_core_t      core_i,
  input  wire logic                    servo_on_i,
  input  wire logic                    alarm_i,
  input  wire logic [7:0]              alarm_code_i,
  input  wire logic                    fwd_inhibit_i,
  input  wire logic                    rev_inhibit_i,
  input  wire logic                    cmd_pulse_i,
  input  wire logic                    cmd_dir_rev_i,
  // Pins from outside the clock domain
  input  wire logic                    ctrl_pwr_i,
  input  wire logic                    main_pwr_i,
  input  wire logic                    cnt_reset_i,
  // Keypad
  input  wire ssm_pkg::ssm_keys_t      keys_i,
  // Panel outputs
  output ssm_pkg::ssm_mode_t           mode_o,
  output ssm_pkg::ssm_bits_t           bits_o,
  output ssm_pkg::ssm_symbol_t         symbol_o,
  output logic [7:0]                   alarm_code_o,
  output logic [3:0]                   mon_index_o,
  output logic                         mon_show_value_o,
  output logic [31:0]                  mon_value_o
);
  import ssm_pkg::*;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Absolute value of a signed 16-bit quantity
  function automatic logic [15:0] abs16(input logic signed [15:0] v);
    // Most negative input maps to 16'h8000
    abs16 = v[15] ? 16'(-v) : 16'(v);
  endfunction : abs16

  // Three-stage pin synchroniser; stage 1 feeds only stage 2
  function automatic logic agree(input logic [2:0] s, input logic prev);
    // Last agreed level holds while stages differ
    agree = (s[1] == s[2]) ? s[2] : prev;
  endfunction : agree

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // Configuration for comparators and monitor
  logic [2:0]  ctrl_q;
  logic [15:0] pos_range_q;
  logic [15:0] match_band_q;
  logic [15:0] rot_speed_q;
  logic        cnt_clr;

  // Counter clear is a strobe, never stored
  assign cnt_clr = wr_i && (addr_i == `SSM_CTRL_ADDR) && wdata_i[`SSM_CTRL_CNT_CLR];

  // Software-written configuration
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      ctrl_q       <= 3'h0;
      pos_range_q  <= `SSM_POS_RANGE_RST;
      match_band_q <= `SSM_MATCH_BAND_RST;
      rot_speed_q  <= `SSM_ROT_SPEED_RST;
    end else if (wr_i) begin
      case (addr_i)
        `SSM_CTRL_ADDR: begin
          ctrl_q[`SSM_CTRL_PULSE_MODE] <= wdata_i[`SSM_CTRL_PULSE_MODE];
          ctrl_q[`SSM_CTRL_ABS_ENC]    <= wdata_i[`SSM_CTRL_ABS_ENC];
          ctrl_q[`SSM_CTRL_CNT_CLR]    <= 1'b0;  // Clear is self-resetting
        end
        `SSM_POS_RANGE_ADDR:  pos_range_q  <= wdata_i[15:0];
        `SSM_MATCH_BAND_ADDR: match_band_q <= wdata_i[15:0];
        `SSM_ROT_SPEED_ADDR:  rot_speed_q  <= wdata_i[15:0];
        // Unmapped offsets are ignored
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  // Bit 0 takes the raw pin
  logic [2:0] ctrl_pwr_s_q, main_pwr_s_q, cnt_rst_s_q;
  // Agreed levels, one cycle ahead of the bits
  logic       ctrl_pwr_q, main_pwr_q, cnt_rst_q;

  // Async pins pass three stages; a change counts once stages 2 and 3 agree
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      ctrl_pwr_s_q <= 3'h0;
      main_pwr_s_q <= 3'h0;
      cnt_rst_s_q  <= 3'h0;
      ctrl_pwr_q   <= 1'b0;
      main_pwr_q   <= 1'b0;
      cnt_rst_q    <= 1'b0;
    end else begin
      ctrl_pwr_s_q <= {ctrl_pwr_s_q[1:0], ctrl_pwr_i};
      main_pwr_s_q <= {main_pwr_s_q[1:0], main_pwr_i};
      cnt_rst_s_q  <= {cnt_rst_s_q[1:0], cnt_reset_i};
      // Stage 1 may be metastable, so it is never compared
      ctrl_pwr_q   <= agree(ctrl_pwr_s_q, ctrl_pwr_q);
      main_pwr_q   <= agree(main_pwr_s_q, main_pwr_q);
      cnt_rst_q    <= agree(cnt_rst_s_q, cnt_rst_q);
    end
  end

  // ----------------------------------------------------------------
  // Command pulse handling
  // ----------------------------------------------------------------
  logic        pulse_prev_q;
  logic        pulse_edge;
  logic [19:0] pulse_hold_q;
  logic [23:0] win_cnt_q;
  logic [31:0] win_pulses_q;
  logic [31:0] freq_q;
  // Running count wraps silently
  logic signed [31:0] pulse_total_q;

  // Rising edge of the same-clock pulse input
  assign pulse_edge = cmd_pulse_i && !pulse_prev_q;

  // Hold timer keeps the indicator lit between pulses of a train
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      pulse_prev_q <= 1'b0;
      pulse_hold_q <= 20'h0;
    end else begin
      pulse_prev_q <= cmd_pulse_i;
      // Each edge restarts the hold
      if (pulse_edge)
        pulse_hold_q <= `SSM_PULSE_HOLD_CYC;
      else if (pulse_hold_q != 20'h0)
        pulse_hold_q <= pulse_hold_q - 20'h1;
    end
  end

  // Fixed gate window counts edges; result is pulses per second
  // Refreshes once per window; rates above half the clock are lost
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      win_cnt_q    <= 24'h0;
      win_pulses_q <= 32'h0;
      freq_q       <= 32'h0;
    end else if (win_cnt_q == `SSM_FREQ_WIN_CYC - 24'd1) begin
      win_cnt_q    <= 24'h0;
      win_pulses_q <= 32'(pulse_edge);
      // An edge in the closing cycle opens the next count
      freq_q       <= 32'(win_pulses_q * `SSM_FREQ_PER_SEC);
    end else begin
      win_cnt_q    <= win_cnt_q + 24'h1;
      win_pulses_q <= win_pulses_q + 32'(pulse_edge);
    end
  end

  // Running input pulse count, signed by direction; software may zero it
  // A clear beside a pulse edge wins
  always_ff @(posedge core_clk_i) begin
    if (rst_i || cnt_clr)
      pulse_total_q <= 32'sh0;
    else if (pulse_edge)
      pulse_total_q <= cmd_dir_rev_i ? pulse_total_q - 32'sh1 : pulse_total_q + 32'sh1;
  end

  // ----------------------------------------------------------------
  // Status indicator bits and symbol
  // ----------------------------------------------------------------
  logic [3:0]  dim_q;
  // Magnitudes for the unsigned compares
  logic [15:0] speed_abs, cmd_abs, dev_abs;
  // Seventeen bits, so extremes cannot wrap
  logic signed [16:0] speed_err;

  assign speed_abs = abs16(core_i.speed_fb);
  assign cmd_abs   = abs16(core_i.speed_cmd);
  assign dev_abs   = core_i.deviation[31] ? 16'(-core_i.deviation) : 16'(core_i.deviation);
  assign speed_err = 17'(core_i.speed_fb) - 17'(core_i.speed_cmd);

  // Dim phase counter: the lamp is driven on one cycle per period
  // Too fast to flicker; seen as dimmed
  always_ff @(posedge core_clk_i) begin
    if (rst_i || dim_q == `SSM_DIM_PERIOD)
      dim_q <= 4'h0;
    else
      dim_q <= dim_q + 4'h1;
  end

  // Indicator bits, one cycle behind their inputs
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      bits_o <= '0;
    end else begin
      // Supply levels and base block
      bits_o.ctrl_pwr    <= ctrl_pwr_q;
      bits_o.main_pwr    <= main_pwr_q;
      bits_o.base_block  <= !servo_on_i || (dim_q == 4'h0);
      // Speed match compares signed; a residue past 16 bits is out of range
      bits_o.pos_done    <= (dev_abs < pos_range_q)
                            && (core_i.deviation[31:16] == {16{core_i.deviation[31]}});
      bits_o.speed_match <= (speed_err <= signed'(17'(match_band_q)))
                            && (speed_err >= -signed'(17'(match_band_q)));
      bits_o.rotating    <= speed_abs >= rot_speed_q;
      // Input activity
      bits_o.pulse_in    <= pulse_hold_q != 20'h0;
      bits_o.speed_in    <= cmd_abs >= rot_speed_q;
      bits_o.torque_in   <= abs16(core_i.torque_cmd) >= `SSM_TORQUE_TENTH;
      bits_o.cnt_reset   <= cnt_rst_q;
    end
  end

  // Alarm outranks travel inhibits, which outrank run/unpowered
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      symbol_o     <= SSM_SYM_UNPOWERED;
      alarm_code_o <= 8'h00;
    end else begin
      // Code reads zero with no alarm
      alarm_code_o <= alarm_i ? alarm_code_i : 8'h00;
      if (alarm_i)
        symbol_o <= SSM_SYM_ALARM;
      else if (fwd_inhibit_i)
        symbol_o <= SSM_SYM_FWD_INHIBIT;
      else if (rev_inhibit_i)
        symbol_o <= SSM_SYM_REV_INHIBIT;
      else if (servo_on_i)
        symbol_o <= SSM_SYM_RUN;
      else
        symbol_o <= SSM_SYM_UNPOWERED;
    end
  end

  // ----------------------------------------------------------------
  // Keypad mode and monitor navigation
  // ----------------------------------------------------------------
  // Mode key steps status, settings, monitor, alarm history, and wraps
  // Settings and alarm history content live outside this block
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      mode_o <= SSM_MODE_STATUS;
    end else if (keys_i.mode_set) begin
      case (mode_o)
        SSM_MODE_STATUS:   mode_o <= SSM_MODE_SETTINGS;
        SSM_MODE_SETTINGS: mode_o <= SSM_MODE_MONITOR;
        SSM_MODE_MONITOR:  mode_o <= SSM_MODE_ALARM;
        SSM_MODE_ALARM:    mode_o <= SSM_MODE_STATUS;
        // Unused encodings fall back to status
        default:           mode_o <= SSM_MODE_STATUS;
      endcase
    end
  end

  // Index moves only while the index itself is shown; ends saturate
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      mon_index_o      <= `SSM_MON_FIRST;
      mon_show_value_o <= 1'b0;
    end else if (mode_o != SSM_MODE_MONITOR) begin
      // Monitor mode always reopens on the index view
      mon_show_value_o <= 1'b0;
    end else if (keys_i.mode_set) begin
      mon_show_value_o <= 1'b0;
    end else if (keys_i.data) begin
      // Data key flips index and value
      mon_show_value_o <= !mon_show_value_o;
    end else if (!mon_show_value_o) begin
      // Up and down act on the index view only
      if (keys_i.up && mon_index_o != `SSM_MON_LAST)
        mon_index_o <= mon_index_o + 4'h1;
      else if (keys_i.down && mon_index_o != `SSM_MON_FIRST)
        mon_index_o <= mon_index_o - 4'h1;
    end
  end

  // ----------------------------------------------------------------
  // Monitor value selection
  // ----------------------------------------------------------------
  logic [31:0] u_scaled;

  // Incremental: 4096 per quarter turn; absolute: 32768 per full turn
  // Modulo keeps the count within one span
  assign u_scaled = ctrl_q[`SSM_CTRL_ABS_ENC]
                    ? core_i.pos_from_u % `SSM_ABS_TURN_PULSES
                    : core_i.pos_from_u % `SSM_INC_QTR_PULSES;

  // Pulse rate to r/min assumes one encoder turn per turn's worth of pulses
  // Value follows the index one cycle later
  // Signed quantities are sign-extended
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      mon_value_o <= 32'h0;
    end else begin
      case (mon_index_o)
        4'h0: mon_value_o <= 32'(core_i.speed_fb);
        4'h1: mon_value_o <= ctrl_q[`SSM_CTRL_PULSE_MODE]
                             ? 32'h0 : 32'(core_i.speed_cmd);
        4'h2: mon_value_o <= 32'(core_i.torque_cmd);
        4'h3: mon_value_o <= u_scaled;
        4'h4: mon_value_o <= 32'(core_i.elec_angle);
        // Flag words pass through untouched
        4'h5: mon_value_o <= 32'(core_i.status_a);
        4'h6: mon_value_o <= 32'(core_i.status_b);
        4'h7: mon_value_o <= 32'(64'(freq_q) * 64'd60 / 64'(
                             ctrl_q[`SSM_CTRL_ABS_ENC] ? `SSM_ABS_TURN_PULSES
                                                       : `SSM_INC_TURN_PULSES));
        4'h8: mon_value_o <= core_i.deviation;
        4'h9: mon_value_o <= pulse_total_q;
        default: mon_value_o <= 32'h0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Register read port
  // ----------------------------------------------------------------
  // Data stand one cycle after the strobe, else zero
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      rdata_o <= 32'h0;
    end else if (rd_i) begin
      case (addr_i)
        `SSM_CTRL_ADDR:       rdata_o <= {29'h0, ctrl_q};
        `SSM_POS_RANGE_ADDR:  rdata_o <= {16'h0, pos_range_q};
        `SSM_MATCH_BAND_ADDR: rdata_o <= {16'h0, match_band_q};
        `SSM_ROT_SPEED_ADDR:  rdata_o <= {16'h0, rot_speed_q};
        `SSM_STATUS_ADDR:     rdata_o <= {19'h0, symbol_o, bits_o};
        `SSM_VIEW_ADDR:       rdata_o <= {25'h0, mon_show_value_o, mode_o, mon_index_o};
        `SSM_VALUE_ADDR:      rdata_o <= mon_value_o;
        `SSM_PULSE_CNT_ADDR:  rdata_o <= pulse_total_q;
        // Unmapped offsets read as zero
        default:              rdata_o <= 32'h0;
      endcase
    end else begin
      rdata_o <= 32'h0;
    end
  end
endmodule : ssm_display

// ### hw/ssm_pkg.sv
// Types shared by the status and monitor display
package ssm_pkg;
  typedef enum logic [1:0] {
    SSM_MODE_STATUS,
    SSM_MODE_SETTINGS,
    SSM_MODE_MONITOR,
    SSM_MODE_ALARM
  } ssm_mode_t;

  typedef enum logic [2:0] {
    SSM_SYM_UNPOWERED,
    SSM_SYM_RUN,
    SSM_SYM_FWD_INHIBIT,
    SSM_SYM_REV_INHIBIT,
    SSM_SYM_ALARM
  } ssm_symbol_t;

  // Measured quantities from the control core
  typedef struct packed {
    logic signed [15:0] speed_fb;
    logic signed [15:0] speed_cmd;
    logic signed [15:0] torque_cmd;
    logic [31:0]        pos_from_u;
    logic [15:0]        elec_angle;
    logic signed [31:0] deviation;
    logic [19:0]        status_a;
    logic [19:0]        status_b;
  } ssm_core_t;

  // Individual status indicator bits
  typedef struct packed {
    logic ctrl_pwr;
    logic main_pwr;
    logic base_block;
    logic pos_done;
    logic speed_match;
    logic rotating;
    logic pulse_in;
    logic speed_in;
    logic torque_in;
    logic cnt_reset;
  } ssm_bits_t;

  // Keypad key presses, one-cycle pulses
  typedef struct packed {
    logic mode_set;
    logic up;
    logic down;
    logic data;
  } ssm_keys_t;
endpackage : ssm_pkg

// ### hw/ssm_regs.svh
// Register offsets, field positions and constants of the status and monitor display
`ifndef SSM_REGS_SVH
`define SSM_REGS_SVH
// Register offsets (word index = byte address / 4)
`define SSM_CTRL_ADDR       8'h00
`define SSM_POS_RANGE_ADDR  8'h04
`define SSM_MATCH_BAND_ADDR 8'h08
`define SSM_ROT_SPEED_ADDR  8'h0c
`define SSM_STATUS_ADDR     8'h10
`define SSM_VIEW_ADDR       8'h14
`define SSM_VALUE_ADDR      8'h18
`define SSM_PULSE_CNT_ADDR  8'h1c
`define SSM_ADDR_W          8
// Control register fields
`define SSM_CTRL_PULSE_MODE 0
`define SSM_CTRL_ABS_ENC    1
`define SSM_CTRL_CNT_CLR    2
// Reset values of the threshold registers
`define SSM_POS_RANGE_RST   16'h000a
`define SSM_MATCH_BAND_RST  16'h000a
`define SSM_ROT_SPEED_RST   16'h0014
// Torque command threshold: ten percent, rated torque is 100
`define SSM_TORQUE_TENTH    16'h000a
// Monitor index range
`define SSM_MON_FIRST       4'h0
`define SSM_MON_LAST        4'h9
// Encoder scaling: pulses per quarter turn and per turn (incremental), or per turn (absolute)
`define SSM_INC_QTR_PULSES  32'h0000_1000
`define SSM_ABS_TURN_PULSES 32'h0000_8000
`define SSM_INC_TURN_PULSES 32'h0000_4000
// Dim duty for the base-block indicator: lit one cycle in this many plus one
`define SSM_DIM_PERIOD      4'h7
// Command pulse frequency window: 10 ms at 100 MHz
`define SSM_FREQ_WIN_CYC    24'd1000000
`define SSM_FREQ_PER_SEC    32'd100
// Pulse activity timeout: 1 ms at 100 MHz
`define SSM_PULSE_HOLD_CYC  20'd100000
`endif

// ### tb/ssm_display_asserts.sv
// Port checker for the status and monitor display
`timescale 1ns/1ns
module ssm_display_asserts (
  input wire logic                 core_clk_i,
  input wire logic                 rst_i,
  input wire logic                 rd_i,
  input wire logic [31:0]          rdata_o,
  input wire ssm_pkg::ssm_core_t   core_i,
  input wire logic                 servo_on_i,
  input wire logic                 alarm_i,
  input wire logic [7:0]           alarm_code_i,
  input wire ssm_pkg::ssm_keys_t   keys_i,
  input wire ssm_pkg::ssm_mode_t   mode_o,
  input wire ssm_pkg::ssm_bits_t   bits_o,
  input wire ssm_pkg::ssm_symbol_t symbol_o,
  input wire logic [7:0]           alarm_code_o,
  input wire logic [3:0]           mon_index_o,
  input wire logic                 mon_show_value_o
);
  import ssm_pkg::*;
  logic live_q;
  // Indicators lag one cycle, so the edge right after reset still shows reset values
  always_ff @(posedge core_clk_i) live_q <= !rst_i;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  torque_flag_a:
    assert property (live_q |-> bits_o.torque_in == ($past(core_i.torque_cmd) >= 16'sd10
      || $past(core_i.torque_cmd) <= -16'sd10)) else $error("torque flag wrong");
  shared_thresh_a:
    assert property (live_q && $past(core_i.speed_fb) == $past(core_i.speed_cmd)
      |-> bits_o.speed_in == bits_o.rotating) else $error("speed flags disagree");
  base_full_a:
    assert property (live_q && !$past(servo_on_i) |-> bits_o.base_block)
    else $error("base block not lit");
  base_dim_a:
    assert property (live_q && $past(servo_on_i) && servo_on_i && bits_o.base_block
      |=> !bits_o.base_block) else $error("base block not dimmed");
  sym_alarm_a:
    assert property (live_q && $past(alarm_i) |-> symbol_o == SSM_SYM_ALARM
      && alarm_code_o == $past(alarm_code_i)) else $error("alarm symbol wrong");
  mode_step_a:
    assert property (keys_i.mode_set |=> mode_o == ssm_mode_t'($past(mode_o) + 2'd1))
    else $error("mode step wrong");
  idx_up_a:
    assert property (mode_o == SSM_MODE_MONITOR && !mon_show_value_o && keys_i == 4'b0100
      && mon_index_o < 4'h9 |=> mon_index_o == $past(mon_index_o) + 4'h1)
    else $error("index step wrong");
  show_hold_a:
    assert property (mon_show_value_o && (keys_i == 4'b0100 || keys_i == 4'b0010)
      |=> $stable(mon_index_o)) else $error("index moved while value shown");
  rd_idle_a:
    assert property (!rd_i |=> rdata_o == 32'h0) else $error("read data not cleared");
endmodule : ssm_display_asserts
bind ssm_display ssm_display_asserts u_chk (.core_clk_i, .rst_i, .rd_i, .rdata_o, .core_i,
  .servo_on_i, .alarm_i, .alarm_code_i, .keys_i, .mode_o, .bits_o, .symbol_o, .alarm_code_o,
  .mon_index_o, .mon_show_value_o);

// ### tb/ssm_keypad_model.sv
// Keypad side of the operator panel: issues one-cycle key pulses
`timescale 1ns/1ns
module ssm_keypad_model (
  input  wire logic         core_clk_i,
  output ssm_pkg::ssm_keys_t keys_o
);
  import ssm_pkg::*;
  initial keys_o = '0;
  // One key per press, bit 3 mode, 2 up, 1 down, 0 data; never two keys at once
  task automatic press(input int k);
    @(posedge core_clk_i);
    keys_o <= ssm_keys_t'(4'h1 << k);
    @(posedge core_clk_i);
    keys_o <= '0;
  endtask : press
endmodule : ssm_keypad_model

// ### tb/tb.sv
// Self-checking bench for the status and monitor display
`timescale 1ns/1ns
module tb;
  import ssm_pkg::*;
  logic        core_clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic [7:0]  addr_i = 8'h00;
  logic [31:0] wdata_i = 32'h0;
  logic        wr_i = 1'b0, rd_i = 1'b0;
  logic [31:0] rdata_o, mon_value_o;
  ssm_core_t   core_i = '0;
  logic        servo_on_i = 1'b0, alarm_i = 1'b0, fwd_inhibit_i = 1'b0, rev_inhibit_i = 1'b0;
  logic [7:0]  alarm_code_i = 8'h00, alarm_code_o;
  logic        cmd_pulse_i = 1'b0, cmd_dir_rev_i = 1'b0;
  logic        ctrl_pwr_i = 1'b0, main_pwr_i = 1'b0, cnt_reset_i = 1'b0;
  ssm_keys_t   keys_i;
  ssm_mode_t   mode_o;
  ssm_bits_t   bits_o;
  ssm_symbol_t symbol_o;
  logic [3:0]  mon_index_o;
  logic        mon_show_value_o;
  int          err_total = 0, checks = 0, cyc = 0, pulses = 0, n, f, c;
  int          rng = 10, band = 10, rot = 20;
  bit          pin = 1'b0;
  ssm_display DUT (.core_clk_i, .rst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .core_i,
    .servo_on_i, .alarm_i, .alarm_code_i, .fwd_inhibit_i, .rev_inhibit_i, .cmd_pulse_i,
    .cmd_dir_rev_i, .ctrl_pwr_i, .main_pwr_i, .cnt_reset_i, .keys_i, .mode_o, .bits_o,
    .symbol_o, .alarm_code_o, .mon_index_o, .mon_show_value_o, .mon_value_o);
  ssm_keypad_model u_pad (.core_clk_i, .keys_o(keys_i));
  always #5 core_clk_i = ~core_clk_i;
  // ----
  // Helpers
  // ----
  task automatic close_out;
    $display("Checks %0d, mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : close_out
  // Run needs about 360 cycles; the ceiling leaves ample slack
  always @(posedge core_clk_i) begin
    cyc++;
    if (cyc > 20000) begin
      err_total++;
      close_out();
    end
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge core_clk_i);
    wr_i <= 1'b0;
  endtask : wr
  // Read data stand only in the cycle after the strobe
  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] exp);
    @(posedge core_clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge core_clk_i);
    rd_i <= 1'b0;
    #1 chk(nm, rdata_o, exp);
  endtask : rdc
  task automatic settle;
    repeat (2) @(posedge core_clk_i);
    #1;
  endtask : settle
  task automatic key(input int k);
    u_pad.press(k);
    #1;
  endtask : key
  task automatic pulse(input int k);
    repeat (k) begin
      @(posedge core_clk_i) cmd_pulse_i <= 1'b1;
      @(posedge core_clk_i) cmd_pulse_i <= 1'b0;
    end
    pulses += k;
    pin = 1'b1;
  endtask : pulse
  function automatic int iabs(input int v);
    return v < 0 ? -v : v;
  endfunction : iabs
  // Base block bit is masked while the servo is on, since dimming is checked apart
  task automatic ind;
    logic [9:0] e;
    logic [9:0] m;
    f = core_i.speed_fb;
    c = core_i.speed_cmd;
    e = {ctrl_pwr_i, main_pwr_i, !servo_on_i, iabs(core_i.deviation) < rng,
         iabs(f - c) <= band, iabs(f) >= rot, pin, iabs(c) >= rot,
         iabs(core_i.torque_cmd) >= 10, cnt_reset_i};
    m = servo_on_i ? 10'h37f : 10'h3ff;
    chk("bits", bits_o & m, e & m);
    chk("symbol", symbol_o, alarm_i ? SSM_SYM_ALARM : fwd_inhibit_i ? SSM_SYM_FWD_INHIBIT :
        rev_inhibit_i ? SSM_SYM_REV_INHIBIT : servo_on_i ? SSM_SYM_RUN : SSM_SYM_UNPOWERED);
    chk("code", alarm_code_o, alarm_i ? alarm_code_i : 8'h00);
  endtask : ind
  // Bit m set means pulse-train mode with an absolute encoder
  function automatic logic [31:0] mon_exp(input int i, input bit m);
    case (i)
      0: return 32'(core_i.speed_fb);
      1: return m ? 32'h0 : 32'(core_i.speed_cmd);
      2: return 32'(core_i.torque_cmd);
      3: return core_i.pos_from_u % (m ? 32768 : 4096);
      4: return 32'(core_i.elec_angle);
      5: return 32'(core_i.status_a);
      6: return 32'(core_i.status_b);
      7: return 32'h0; // No gate window has closed yet
      8: return core_i.deviation;
      default: return pulses;
    endcase
  endfunction : mon_exp
  // ----
  // Main sequence
  // ----
  initial begin
    n = $urandom(59705);
    repeat (12) @(posedge core_clk_i);
    rst_i <= 1'b0;
    @(posedge core_clk_i);
    #1 chk("mode", mode_o, SSM_MODE_STATUS);
    rdc("range", 8'h04, 32'd10);
    rdc("band", 8'h08, 32'd10);
    rdc("rot", 8'h0c, 32'd20);
    rdc("unmapped", 8'h20, 32'h0);
    @(posedge core_clk_i);
    ctrl_pwr_i <= 1'b1;
    main_pwr_i <= 1'b1;
    cnt_reset_i <= 1'b1;
    repeat (6) @(posedge core_clk_i);
    #1 ind();
    pulse(5);
    settle();
    ind();
    rdc("total", 8'h1c, pulses);
    wr(8'h00, 32'h4);
    pulses = 0;
    rdc("cleared", 8'h1c, 32'h0);
    $display("Test supplies and pulses done");
    rng = $urandom_range(30);
    band = $urandom_range(30);
    rot = $urandom_range(40);
    wr(8'h04, rng);
    wr(8'h08, band);
    wr(8'h0c, rot);
    @(posedge core_clk_i) cnt_reset_i <= 1'b0;
    repeat (6) @(posedge core_clk_i);
    for (int i = 0; i < 60; i++) begin
      f = $urandom_range(120) - 60;
      c = (i % 4 == 0) ? f : $urandom_range(120) - 60;
      @(posedge core_clk_i);
      core_i.speed_fb <= 16'(f);
      core_i.speed_cmd <= 16'(c);
      core_i.torque_cmd <= 16'($urandom_range(40) - 20);
      core_i.deviation <= $urandom_range(60) - 30;
      servo_on_i <= 1'($urandom);
      alarm_i <= ($urandom_range(3) == 0);
      fwd_inhibit_i <= 1'($urandom);
      rev_inhibit_i <= 1'($urandom);
      alarm_code_i <= 8'($urandom);
      settle();
      ind();
    end
    @(posedge core_clk_i) servo_on_i <= 1'b1;
    n = 0;
    repeat (2) @(posedge core_clk_i);
    repeat (16) @(posedge core_clk_i) #1 n += bits_o.base_block;
    chk("dim", n, 2);
    $display("Test indicators done");
    @(posedge core_clk_i);
    core_i.speed_fb <= 16'($urandom_range(3000));
    core_i.speed_cmd <= 16'($urandom_range(3000));
    core_i.torque_cmd <= 16'($urandom_range(300));
    core_i.pos_from_u <= $urandom;
    core_i.elec_angle <= 16'($urandom_range(359));
    core_i.deviation <= $urandom_range(5000);
    core_i.status_a <= 20'($urandom);
    core_i.status_b <= 20'($urandom);
    pulse(3);
    key(3);
    key(3);
    chk("mode", mode_o, SSM_MODE_MONITOR);
    for (int i = 0; i < 10; i++) begin
      if (i > 0) key(2);
      settle();
      chk("index", mon_index_o, i);
      if (i < 5) chk("value", mon_value_o, mon_exp(i, 0));
      else chk("value", mon_value_o, mon_exp(i, 0));
    end
    key(2);
    chk("index", mon_index_o, 9);
    key(0);
    key(1);
    chk("show", {mon_show_value_o, mon_index_o}, 5'h19);
    key(0);
    wr(8'h00, 32'h3);
    for (int i = 9; i >= 0; i--) begin
      if (i < 9) key(1);
      settle();
      chk("value", mon_value_o, mon_exp(i, 1));
    end
    key(0);
    key(3);
    chk("alarm mode", {mode_o, mon_show_value_o}, {SSM_MODE_ALARM, 1'b0});
    key(3);
    chk("mode", mode_o, SSM_MODE_STATUS);
    $display("Test monitor done");
    close_out();
  end
endmodule : tb
